// File: hw/sasr_device.sv
// How it works
// R01: Select falling starts conversion and frame
// R02: Select fall enables output, holds, samples
// R03: Track again on thirteenth rising edge
// R04: Output floats after 16th fall or deselect
// R05: Host waits quiet time between frames
// R06: Host supplies sixteen shift-clock cycles
// R07: Output bits change on falling edges
// R08: Host captures on following falling edge
// R09: Three zeros, eight bits MSB first, four zeros; the code drives five trailing zeros
// R10: Early select may yield extra leading zero
// R11: Straight binary result, LSB is supply/256
// R12: Deselect after tenth fall aborts, floats output
// R13: Edge counter restarts every frame
`timescale 1ns/10ps
`default_nettype none
module sasr_device (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  sasr_if.dev link,
  input wire logic [7:0] sample_code_i,
  output logic hold_mode_o,
  output logic conv_abort_o,
  output logic frame_active_o
);
  logic sel_q;
  logic sck_q;
  logic active_q;
  logic active_d;
  logic oe_q;
  logic oe_d;
  logic dout_q;
  logic dout_d;
  logic hold_q;
  logic hold_d;
  logic abort_q;
  logic abort_d;
  logic [4:0] fall_cnt_q;
  logic [4:0] fall_cnt_d;
  logic [4:0] rise_cnt_q;
  logic [4:0] rise_cnt_d;
  logic [14:0] shift_q;
  logic [14:0] shift_d;
  logic [14:0] frame_word;
  logic sel_fall;
  logic sel_rise;
  logic sel_steady;
  logic sck_fall;
  logic sck_rise;
  logic last_fall;
  logic track_rise;
  logic abort_win;
  logic frame_close;

  // R01: select edges from sampled pin
  assign sel_fall = sel_q && !link.frame_sel_n;
  assign sel_rise = !sel_q && link.frame_sel_n;
  // Select edges win over clock edges in one cycle
  assign sel_steady = !sel_fall && !sel_rise;

  // R13: shift edges ignored outside a frame
  // Pins sampled once, so edges act a cycle late
  assign sck_fall = sck_q && !link.shift_clk && active_q && sel_steady;
  assign sck_rise = !sck_q && link.shift_clk && active_q && sel_steady;

  // R04: sixteenth falling edge
  assign last_fall = sck_fall && (fall_cnt_q == sasr_pkg::LAST_FALL - 5'h01);
  // R03: thirteenth rising edge
  assign track_rise = sck_rise && (rise_cnt_q == sasr_pkg::TRACK_RISE - 5'h01);
  // R12: abort window from tenth fall
  // Earlier deselect only floats; low power out of scope
  assign abort_win = fall_cnt_q >= sasr_pkg::ABORT_FALL;
  // R04: frame closes on deselect or last fall
  assign frame_close = sel_rise || last_fall;

  // R09: first zero already on the pin
  assign frame_word = {2'b00, sample_code_i, 5'h00};

  // R01: frame opens on select fall
  assign active_d = sel_fall ? 1'b1 :
    frame_close ? 1'b0 :
    active_q;
  // R02: drive at select fall; R04: float at close
  assign oe_d = sel_fall ? 1'b1 :
    frame_close ? 1'b0 :
    oe_q;
  // R02: hold at select fall; R03: track again
  assign hold_d = sel_fall ? 1'b1 :
    (frame_close || track_rise) ? 1'b0 :
    hold_q;
  // R12: one-cycle pulse on late deselect
  assign abort_d = sel_rise && active_q && abort_win;

  // R13: counters restart with every frame
  assign fall_cnt_d = sel_fall ? sasr_pkg::CNT_RESET :
    sck_fall ? fall_cnt_q + 5'h01 :
    fall_cnt_q;
  assign rise_cnt_d = sel_fall ? sasr_pkg::CNT_RESET :
    sck_rise ? rise_cnt_q + 5'h01 :
    rise_cnt_q;

  // R07: launch on falling edge; R11: code as given
  assign dout_d = sel_fall ? 1'b0 :
    sck_fall ? shift_q[14] :
    dout_q;
  assign shift_d = sel_fall ? frame_word :
    sck_fall ? {shift_q[13:0], 1'b0} :
    shift_q;

  // Outputs straight from flops
  assign link.serial_result_out = dout_q;
  assign link.serial_result_oe = oe_q;
  assign hold_mode_o = hold_q;
  assign conv_abort_o = abort_q;
  assign frame_active_o = active_q;

  // Reset to idle levels, so no false edge
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sel_q <= 1'b1;
    end else begin
      sel_q <= link.frame_sel_n;
    end
  end

  // Shift clock idles high
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sck_q <= 1'b1;
    end else begin
      sck_q <= link.shift_clk;
    end
  end

  // R01: frame state
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      active_q <= 1'b0;
    end else begin
      active_q <= active_d;
    end
  end

  // R04: output enable
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      oe_q <= 1'b0;
    end else begin
      oe_q <= oe_d;
    end
  end

  // R07: output bit
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      dout_q <= 1'b0;
    end else begin
      dout_q <= dout_d;
    end
  end

  // R03: hold or track
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      hold_q <= 1'b0;
    end else begin
      hold_q <= hold_d;
    end
  end

  // R12: abort pulse
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      abort_q <= 1'b0;
    end else begin
      abort_q <= abort_d;
    end
  end

  // R13: falling edge count
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      fall_cnt_q <= sasr_pkg::CNT_RESET;
    end else begin
      fall_cnt_q <= fall_cnt_d;
    end
  end

  // R13: rising edge count
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rise_cnt_q <= sasr_pkg::CNT_RESET;
    end else begin
      rise_cnt_q <= rise_cnt_d;
    end
  end

  // R09: frame word shifter
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      shift_q <= 15'h0000;
    end else begin
      shift_q <= shift_d;
    end
  end
endmodule
`default_nettype wire

// File: hw/sasr_pkg.sv
package sasr_pkg;
  localparam int RESULT_W = 8;
  localparam int LEAD_ZEROS = 3;
  localparam int TRAIL_ZEROS = 4;
  localparam int FRAME_BITS = 16;
  localparam int CNT_W = 5;
  localparam logic [4:0] TRACK_RISE = 5'h0D;
  localparam logic [4:0] LAST_FALL = 5'h10;
  localparam logic [4:0] ABORT_FALL = 5'h0A;
  // Host clock divider: half period is SCLK_HALF+1 core cycles
  localparam logic [3:0] SCLK_HALF = 4'h1;
  // Quiet time between frames
  localparam int FRAME_GAP_TIME_NS = 400;
  localparam int CLK_PERIOD_NS = 100;
  localparam int FRAME_GAP_CYC_I = (FRAME_GAP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] FRAME_GAP_CYC = FRAME_GAP_CYC_I[7:0];
  localparam logic [4:0] CNT_RESET = 5'h00;
endpackage

// File: hw/sasr_if.sv
`timescale 1ns/10ps
`default_nettype none
interface sasr_if;
  logic frame_sel_n;
  logic shift_clk;
  logic serial_result_out;
  logic serial_result_oe;
  modport dev (input frame_sel_n, input shift_clk, output serial_result_out, output serial_result_oe);
  modport host (output frame_sel_n, output shift_clk, input serial_result_out, input serial_result_oe);
endinterface
`default_nettype wire

// File: hw/sasr_host.sv
`timescale 1ns/10ps
`default_nettype none
module sasr_host (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  sasr_if.host link,
  input wire logic start_i,
  output logic busy_o,
  output logic [7:0] result_o,
  output logic result_valid_o
);
  typedef enum logic [1:0] {SASR_IDLE, SASR_SHIFT, SASR_GAP} sasr_hstate_t;
  sasr_hstate_t st_q;
  logic sel_n_q, sck_q, busy_q, valid_q;
  logic [3:0] div_q;
  logic [4:0] fall_q;
  logic [15:0] cap_q;
  logic [7:0] res_q, gap_q;
  wire tick = div_q == sasr_pkg::SCLK_HALF;
  assign link.frame_sel_n = sel_n_q;
  assign link.shift_clk = sck_q;
  assign busy_o = busy_q;
  assign result_o = res_q;
  assign result_valid_o = valid_q;
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_q <= SASR_IDLE;
      sel_n_q <= 1'b1;
      sck_q <= 1'b1;
      busy_q <= 1'b0;
      valid_q <= 1'b0;
      div_q <= 4'h0;
      fall_q <= 5'h00;
      cap_q <= 16'h0000;
      res_q <= 8'h00;
      gap_q <= 8'h00;
    end else begin
      valid_q <= 1'b0;
      div_q <= tick ? 4'h0 : div_q + 4'h1;
      case (st_q)
        SASR_IDLE: begin
          // R01: request a sample; clock idles high
          if (start_i) begin
            sel_n_q <= 1'b0;
            busy_q <= 1'b1;
            fall_q <= 5'h00;
            div_q <= 4'h0;
            st_q <= SASR_SHIFT;
          end
        end
        SASR_SHIFT: begin
          if (tick) begin
            sck_q <= ~sck_q;
            if (sck_q) begin
              // R08: capture on falling edge; R10: alignment fixed by count
              cap_q <= {cap_q[14:0], link.serial_result_out};
              fall_q <= fall_q + 5'h01;
            end else if (fall_q == sasr_pkg::LAST_FALL) begin
              // R06: sixteen cycles given; R09: code in bits 12..5
              sel_n_q <= 1'b1;
              sck_q <= 1'b1;
              res_q <= cap_q[12:5];
              valid_q <= 1'b1;
              gap_q <= 8'h00;
              st_q <= SASR_GAP;
            end
          end
        end
        SASR_GAP: begin
          // R05: quiet time before next select
          gap_q <= gap_q + 8'h01;
          if (gap_q >= sasr_pkg::FRAME_GAP_CYC) begin
            busy_q <= 1'b0;
            st_q <= SASR_IDLE;
          end
        end
        default: st_q <= SASR_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// File: verif/sasr_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module sasr_monitor (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic frame_sel_n,
  input wire logic shift_clk,
  input wire logic serial_result_out,
  input wire logic serial_result_oe
);
  logic sck_q;
  logic [4:0] cnt_q;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sck_q <= 1'b1;
      cnt_q <= 5'h00;
    end else begin
      sck_q <= shift_clk;
      cnt_q <= frame_sel_n ? 5'h00 : cnt_q + {4'h0, sck_q & ~shift_clk};
    end
  end
  a_sel_drives: assert property ($fell(frame_sel_n) |-> ##[1:3] serial_result_oe)
    else $error("no drive");
  a_desel_floats: assert property ($rose(frame_sel_n) |-> ##[1:3] !serial_result_oe)
    else $error("no float");
  a_end_floats: assert property (cnt_q == 5'h10 |-> ##[1:2] !serial_result_oe)
    else $error("no end float");
  a_bit_on_fall: assert property ($changed(serial_result_out) && serial_result_oe |-> !sck_q)
    else $error("bad edge");
  a_lead_zero: assert property (serial_result_oe && cnt_q < 5'h02 |-> !serial_result_out)
    else $error("lead bit");
  a_trail_zero: assert property (serial_result_oe && cnt_q > 5'h0C |-> !serial_result_out)
    else $error("trail bit");
  a_frame_gap: assert property ($rose(frame_sel_n) |-> frame_sel_n [*5])
    else $error("gap short");
  a_full_frame: assert property ($rose(frame_sel_n) |-> cnt_q == 5'h10)
    else $error("short frame");
  c_frame: cover property ($rose(frame_sel_n));
  c_one: cover property (serial_result_oe && serial_result_out);
  c_end: cover property (cnt_q == 5'h10);
endmodule
`default_nettype wire

// File: verif/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic start_i = 1'b0;
  logic [7:0] code = 8'h00;
  logic [7:0] res;
  logic valid, busy, hold, abort;
  logic hold_b, act_b;
  logic [7:0] codes [5] = '{8'h00, 8'h01, 8'hA5, 8'h80, 8'hFF};
  int fails = 0;
  int compares = 0;
  int n;
  sasr_if la ();
  sasr_if lb ();
  sasr_host i_sasr_host (.core_clk_i(clk), .reset_n_i(rst_n), .link(la), .start_i(start_i),
    .busy_o(busy), .result_o(res), .result_valid_o(valid));
  sasr_device i_sasr_device (.core_clk_i(clk), .reset_n_i(rst_n), .link(la), .sample_code_i(code),
    .hold_mode_o(hold), .conv_abort_o(), .frame_active_o());
  // Second device faces bench-driven select
  sasr_device i_sasr_device_b (.core_clk_i(clk), .reset_n_i(rst_n), .link(lb), .sample_code_i(code),
    .hold_mode_o(hold_b), .conv_abort_o(abort), .frame_active_o(act_b));
  sasr_monitor i_sasr_monitor (.core_clk_i(clk), .reset_n_i(rst_n), .frame_sel_n(la.frame_sel_n),
    .shift_clk(la.shift_clk), .serial_result_out(la.serial_result_out),
    .serial_result_oe(la.serial_result_oe));
  initial forever #50 clk = ~clk;
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic report_and_stop;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic bounded;
    if (n > 299) begin
      fails++;
      report_and_stop;
    end
  endtask
  task automatic read_sample(input logic [7:0] c);
    code <= c;
    start_i <= 1'b1;
    for (n = 0; n < 300 && valid !== 1'b1; n++) begin
      @(posedge clk);
      start_i <= 1'b0;
    end
    bounded;
    check("result", c, res);
    check("hold", 8'h00, {7'h00, hold});
    for (n = 0; n < 300 && busy !== 1'b0; n++) @(posedge clk);
    bounded;
  endtask
  // Only full sck cycles, so no half edge
  task automatic frame_b(input int f, input logic [7:0] exp);
    logic seen;
    seen = 1'b0;
    lb.frame_sel_n <= 1'b0;
    repeat (2) @(posedge clk);
    repeat (f) begin
      lb.shift_clk <= 1'b0;
      repeat (2) @(posedge clk);
      lb.shift_clk <= 1'b1;
      repeat (2) @(posedge clk);
    end
    check("hold", (f < 13) ? 8'h01 : 8'h00, {7'h00, hold_b});
    check("active", (f < 16) ? 8'h01 : 8'h00, {7'h00, act_b});
    lb.frame_sel_n <= 1'b1;
    repeat (8) begin
      @(posedge clk);
      if (abort === 1'b1) seen = 1'b1;
    end
    check("abort", exp, {7'h00, seen});
    check("float", 8'h00, {7'h00, lb.serial_result_oe});
  endtask
  initial begin
    lb.frame_sel_n = 1'b1;
    lb.shift_clk = 1'b1;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    foreach (codes[i]) read_sample(codes[i]);
    $display("readout test done");
    frame_b(10, 8'h01);
    frame_b(12, 8'h01);
    frame_b(5, 8'h00);
    frame_b(16, 8'h00);
    $display("abort test done");
    report_and_stop;
  end
endmodule
`default_nettype wire
